/* shared/etp_defs.svh */
// Purpose: offsets, field positions and reset values of the edge timed pulse unit
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word
// Notes: definitions only
`ifndef ETP_DEFS_SVH
`define ETP_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ETP_OFS_CONTROL 8'h00
`define ETP_OFS_IRQ_STATUS 8'h04
`define ETP_OFS_IRQ_MASK 8'h08

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define ETP_BIT_MODULE_ON 15
`define ETP_BIT_HALT_IDLE 13
`define ETP_BIT_DELAY_EN 12
`define ETP_BIT_EDGE_ACCEPT 11
`define ETP_BIT_EDGE_ORDER 10
`define ETP_BIT_DISCHARGE 9
`define ETP_BIT_TRIG_EN 8
`define ETP_BIT_E2_POL 7
`define ETP_LSB_E2_SEL 5
`define ETP_BIT_E1_POL 4
`define ETP_LSB_E1_SEL 2
`define ETP_BIT_E2_SEEN 1
`define ETP_BIT_E1_SEEN 0
`define ETP_CTRL_WMASK 16'hbfff

// ----------------------------------------------------------------
// edge source codes
// ----------------------------------------------------------------
`define ETP_SRC_PIN_A 2'h3
`define ETP_SRC_PIN_B 2'h2
`define ETP_SRC_OC1 2'h1
`define ETP_SRC_TMR1 2'h0

// ----------------------------------------------------------------
// reset values and interrupt bits
// ----------------------------------------------------------------
`define ETP_CTRL_RESET 16'h0000
`define ETP_IRQ_RESET 3'h0
`define ETP_IRQ_E1 0
`define ETP_IRQ_E2 1
`define ETP_IRQ_TRIP 2
`define ETP_RESP_OKAY 2'h0
`define ETP_RESP_SLVERR 2'h2

`endif

/* shared/etp_pkg.sv */
// Purpose: types shared by the edge timed pulse unit
// Assumes: nothing
// Notes: constants live in etp_defs.svh
package etp_pkg;
   // delay generation sequence
   typedef enum logic [1:0]
   {
      ST_WAIT,
      ST_CHARGE,
      ST_TRIPPED
   } etp_state_t;
endpackage

/* hdl/etp_sync.sv */
// Purpose: two flip-flop synchroniser for a group of asynchronous levels
// Assumes: each bit is an independent level
// Notes: only the second stage may be read outside
`timescale 1ns/1ps
module etp_sync #(
   parameter int WIDTH = 3
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // levels
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   // first stage feeds the second and nothing else
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

/* hdl/etp_top.sv */
// Purpose: control logic of the edge timed pulse delay unit
// Assumes: comparator output and edge pins are asynchronous; idle, oc1, timer1 on aclk
// Notes: the pulse output is gated, not registered, so its rising edge follows the comparator
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "etp_defs.svh"

module etp_top
   import etp_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // edge sources
   input wire logic ext_edge_pin_a,
   input wire logic ext_edge_pin_b,
   input wire logic output_compare_one,
   input wire logic timer_one,
   // device state and analog interface
   input wire logic cpu_idle,
   input wire logic comparator_two_out,
   output logic current_to_comp_b,
   output logic current_source_on,
   output logic source_discharge_on,
   output logic delayed_pulse_out,
   output logic adc_trigger,
   output logic irq
);
   logic [15:0] ctrl;
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [2:0] sync_q;
   logic prev_e1;
   logic prev_e2;
   logic charge_active;
   etp_state_t state;
   etp_state_t next_state;

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   etp_sync #(.WIDTH(3)) u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in({comparator_two_out, ext_edge_pin_b, ext_edge_pin_a}),
      .sync_out(sync_q)
   );

   // ----------------------------------------------------------------
   // edge selection and detection
   // ----------------------------------------------------------------
   function automatic logic pick_source(input logic [1:0] code, input logic pa,
                                        input logic pb, input logic oc, input logic tm);
      logic res;
      res = tm;
      case (code)
         `ETP_SRC_PIN_A: res = pa;
         `ETP_SRC_PIN_B: res = pb;
         `ETP_SRC_OC1: res = oc;
         default: res = tm;
      endcase
      return res;
   endfunction

   function automatic logic edge_hit(input logic pol, input logic cur, input logic prv);
      return pol ? (cur & ~prv) : (~cur & prv);
   endfunction

   wire comp_s = sync_q[2];
   // halted when off or when idle with the halt bit set
   // idle halt gate
   wire running = ctrl[`ETP_BIT_MODULE_ON] & ~(ctrl[`ETP_BIT_HALT_IDLE] & cpu_idle);
   wire accept = running & ctrl[`ETP_BIT_EDGE_ACCEPT];
   wire lvl_e1 = pick_source(ctrl[`ETP_LSB_E1_SEL +: 2], sync_q[0], sync_q[1],
                             output_compare_one, timer_one);
   wire lvl_e2 = pick_source(ctrl[`ETP_LSB_E2_SEL +: 2], sync_q[0], sync_q[1],
                             output_compare_one, timer_one);
   wire hit_e1 = edge_hit(ctrl[`ETP_BIT_E1_POL], lvl_e1, prev_e1);
   wire hit_e2 = edge_hit(ctrl[`ETP_BIT_E2_POL], lvl_e2, prev_e2);
   // edge 2 waits for edge 1 when ordering is on
   wire ev_e1 = accept & hit_e1;
   wire ev_e2 = accept & hit_e2 & (~ctrl[`ETP_BIT_EDGE_ORDER] | ctrl[`ETP_BIT_E1_SEEN]);
   wire delay_mode = running & ctrl[`ETP_BIT_DELAY_EN];
   wire trip_ev = (state == ST_CHARGE) & comp_s;

   // previous levels for edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         prev_e1 <= 1'b0;
         prev_e2 <= 1'b0;
      end
      else
      begin
         prev_e1 <= lvl_e1;
         prev_e2 <= lvl_e2;
      end
   end

   // ----------------------------------------------------------------
   // delay generation sequence
   // ----------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         ST_WAIT:
         begin
            if (delay_mode && ev_e1)
               next_state = ST_CHARGE;
         end
         ST_CHARGE:
         begin
            // delay set by capacitor charge time
            if (!delay_mode)
               next_state = ST_WAIT;
            else if (comp_s)
               next_state = ST_TRIPPED;
         end
         ST_TRIPPED:
         begin
            // rearm once the capacitor has fallen below the trip point, or at once when delay mode is turned off
            if (!delay_mode || !comp_s)
               next_state = ST_WAIT;
         end
         default: next_state = ST_WAIT;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         state <= ST_WAIT;
      else
         state <= next_state;
   end

   // ----------------------------------------------------------------
   // analog control outputs
   // ----------------------------------------------------------------
   assign charge_active = (state == ST_CHARGE);
   assign current_to_comp_b = delay_mode;
   assign current_source_on = charge_active & delay_mode;
   assign source_discharge_on = running & ctrl[`ETP_BIT_DISCHARGE];
   // comparator level passes straight through the gate, so no clock edge shapes it;
   // the pulse ends a few cycles later when the synchronised trip closes the gate
   // asynchronous pulse gating
   assign delayed_pulse_out = comparator_two_out & charge_active & delay_mode;
   assign irq = |(irq_stat & irq_mask);

   // trigger toward the converter on each trip
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         adc_trigger <= 1'b0;
      else
         adc_trigger <= trip_ev & ctrl[`ETP_BIT_TRIG_EN];
   end

   // ----------------------------------------------------------------
   // axi4-lite slave
   // ----------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire wr_ctrl = do_write & (aw_addr == `ETP_OFS_CONTROL);
   wire wr_stat = do_write & (aw_addr == `ETP_OFS_IRQ_STATUS);
   wire wr_mask = do_write & (aw_addr == `ETP_OFS_IRQ_MASK);
   wire wr_ok = wr_ctrl | wr_stat | wr_mask;
   wire [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}} & `ETP_CTRL_WMASK;
   wire [15:0] ctrl_written = (ctrl & ~lane_mask) | (w_data[15:0] & lane_mask);
   wire [2:0] stat_clear = (wr_stat & w_strb[0]) ? w_data[2:0] : 3'h0;
   wire rd_ctrl = s_axi_araddr == `ETP_OFS_CONTROL;
   wire rd_stat = s_axi_araddr == `ETP_OFS_IRQ_STATUS;
   wire rd_mask = s_axi_araddr == `ETP_OFS_IRQ_MASK;
   wire [31:0] rd_value = rd_ctrl ? {16'h0000, ctrl} :
                          rd_stat ? {29'h0000000, irq_stat} :
                          rd_mask ? {29'h0000000, irq_mask} : 32'h00000000;

   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign s_axi_arready = ~s_axi_rvalid;

   // write address and data captured in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && !aw_held)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         else if (do_write)
            aw_held <= 1'b0;
         if (s_axi_wvalid && !w_held)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         else if (do_write)
            w_held <= 1'b0;
      end
   end

   // write response and read data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ETP_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= `ETP_RESP_OKAY;
         s_axi_rdata <= 32'h00000000;
      end
      else
      begin
         if (do_write)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `ETP_RESP_OKAY : `ETP_RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && !s_axi_rvalid)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_value;
            s_axi_rresp <= (rd_ctrl | rd_stat | rd_mask) ? `ETP_RESP_OKAY : `ETP_RESP_SLVERR;
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // registers; hardware set beats a same-cycle clear
   // ----------------------------------------------------------------
   wire [15:0] ctrl_base = wr_ctrl ? ctrl_written : ctrl;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl <= `ETP_CTRL_RESET;
         irq_stat <= `ETP_IRQ_RESET;
         irq_mask <= `ETP_IRQ_RESET;
      end
      else
      begin
         ctrl <= ctrl_base | {14'h0000, ev_e2, ev_e1};
         irq_stat <= (irq_stat & ~stat_clear) | {trip_ev, ev_e2, ev_e1};
         if (wr_mask && w_strb[0])
            irq_mask <= w_data[2:0];
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_off_no_current: assert property (@(posedge aclk) disable iff (!aresetn)
      !ctrl[`ETP_BIT_MODULE_ON] |-> !current_source_on && !delayed_pulse_out)
      else $error("current source on while module off");
   a_charge_start: assert property (@(posedge aclk) disable iff (!aresetn)
      (state == ST_WAIT && delay_mode && ev_e1) |=> current_source_on || !delay_mode)
      else $error("charging did not start on edge");
   a_trip_stops: assert property (@(posedge aclk) disable iff (!aresetn)
      trip_ev |=> !current_source_on ##1 !current_source_on)
      else $error("charging continued after trip");
   a_idle_halt: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl[`ETP_BIT_HALT_IDLE] && cpu_idle) |-> !current_source_on && !ev_e1 && !ev_e2)
      else $error("unit active in idle with halt set");
   a_route_comp: assert property (@(posedge aclk) disable iff (!aresetn)
      current_to_comp_b == (running && ctrl[`ETP_BIT_DELAY_EN]))
      else $error("current routing mismatch");
   a_edge_seen: assert property (@(posedge aclk) disable iff (!aresetn)
      ev_e1 |=> ctrl[`ETP_BIT_E1_SEEN] && irq_stat[`ETP_IRQ_E1])
      else $error("edge one not flagged");
   a_edge_order: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl[`ETP_BIT_EDGE_ORDER] && !ctrl[`ETP_BIT_E1_SEEN]) |-> !ev_e2)
      else $error("edge two accepted before edge one");
   a_pulse_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      delayed_pulse_out |-> state == ST_CHARGE)
      else $error("pulse outside charge phase");
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(irq_stat[`ETP_IRQ_TRIP]) |-> $past(state) == ST_CHARGE)
      else $error("trip flagged without charge");
   a_read_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule

/* verification/etp_cap_model.sv */
// Purpose: delay capacitor and comparator two behind the pulse unit
// Assumes: charge rises one step per cycle while the current source is on
// Notes: output changes 3 ns after the clock, so it is asynchronous to aclk
`timescale 1ns/1ps
module etp_cap_model #(
   parameter int CHARGE_CYC = 6
)
(
   // clock
   input wire logic aclk,
   // analog side
   input wire logic current_on,
   output logic comp_out
);
   int level = 0;
   // capacitor voltage: charges while fed, bleeds off otherwise
   always @(posedge aclk)
   begin
      if (current_on)
         level <= level + 1;
      else if (level > 0)
         level <= level - 1;
   end
   // comparator trips above the reference, skewed off the clock
   // stands for converter channel 31: no stray pin capacitance
   assign #3 comp_out = (level >= CHARGE_CYC);
endmodule

/* verification/tb_top.sv */
// Purpose: self-checking bench of the edge timed pulse unit
// Assumes: bready and rready held high; pin latency a few cycles
// Notes: ready and answers are sampled on the falling edge before the taking edge
`timescale 1ns/1ps
`include "etp_defs.svh"
module tb_top;
   localparam int CHG = 6;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic pin_a = 0, pin_b = 0, oc = 0, tm = 0, idle = 0, comp;
   logic cur_b, cur_on, dis_on, pulse, adc, irq, adc_seen = 0;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   realtime t_rise = 0, t_edge;
   logic [31:0] rd;
   logic [31:0] cfg;
   logic [31:0] on_acc = (32'h1 << `ETP_BIT_MODULE_ON) | (32'h1 << `ETP_BIT_EDGE_ACCEPT);

   etp_top etp_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .ext_edge_pin_a(pin_a),
      .ext_edge_pin_b(pin_b), .output_compare_one(oc), .timer_one(tm), .cpu_idle(idle),
      .comparator_two_out(comp), .current_to_comp_b(cur_b), .current_source_on(cur_on),
      .source_discharge_on(dis_on), .delayed_pulse_out(pulse), .adc_trigger(adc), .irq(irq));
   etp_cap_model #(.CHARGE_CYC(CHG)) etp_cap_model_i (.aclk(aclk), .current_on(cur_on),
      .comp_out(comp));

   // ----------------------------------------------------------------
   // clock, reset, watchdog and observers
   // ----------------------------------------------------------------
   initial
   begin
      aclk = 0;
      forever #4 aclk = ~aclk;
   end
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (adc)
         adc_seen <= 1;
      if (cyc > 20000)
      begin
         $display("ERROR %0t watchdog ceiling reached", $time);
         n_mismatch++;
         summarize();
      end
   end
   always @(posedge pulse)
      t_rise = $realtime;

   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // ----------------------------------------------------------------
   // register bus master
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta, tw, b;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do
      begin
         @(negedge aclk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         b = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
         if (ta)
            s_axi_awvalid <= 0;
         if (tw)
            s_axi_wvalid <= 0;
      end while (!b);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      logic ta, v;
      logic [1:0] r;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      do
      begin
         @(negedge aclk);
         ta = s_axi_arvalid & s_axi_arready;
         v = s_axi_rvalid;
         rd = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta)
            s_axi_arvalid <= 0;
      end while (!v);
      chk(rd, e);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic src(input logic [1:0] s, input logic v);
      @(posedge aclk);
      case (s)
         `ETP_SRC_PIN_A: pin_a <= v;
         `ETP_SRC_PIN_B: pin_b <= v;
         `ETP_SRC_OC1: oc <= v;
         default: tm <= v;
      endcase
      t_edge = $realtime;
      tick(5);
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_edges();
      for (int s = 0; s < 4; s++)
         for (int p = 0; p < 2; p++)
         begin
            // ordering keeps edge two (timer, falling) out of these checks
            cfg = on_acc | (32'h1 << `ETP_BIT_EDGE_ORDER) | (s << `ETP_LSB_E1_SEL);
            cfg = cfg | (p << `ETP_BIT_E1_POL);
            src(2'(s), 1'(p));
            // a source switch can look like an edge; the second write clears it
            wr(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
            wr(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
            src(2'(s), !p);
            rdc(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
            src(2'(s), 1'(p));
            rdc(`ETP_OFS_CONTROL, cfg | 32'h1, `ETP_RESP_OKAY);
         end
      // edge two on pin b, rising, held back until edge one is seen
      cfg = on_acc | (32'h1 << `ETP_BIT_EDGE_ORDER) | (32'h1 << `ETP_BIT_E2_POL);
      cfg = cfg | (32'(`ETP_SRC_PIN_B) << `ETP_LSB_E2_SEL) | 32'h1c;
      src(`ETP_SRC_PIN_A, 1'b0);
      src(`ETP_SRC_PIN_B, 1'b0);
      wr(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
      src(`ETP_SRC_PIN_B, 1'b1);
      rdc(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
      src(`ETP_SRC_PIN_A, 1'b1);
      src(`ETP_SRC_PIN_B, 1'b0);
      src(`ETP_SRC_PIN_B, 1'b1);
      rdc(`ETP_OFS_CONTROL, cfg | 32'h3, `ETP_RESP_OKAY);
   endtask
   task automatic t_off_idle();
      cfg = (32'h1 << `ETP_BIT_EDGE_ACCEPT) | (32'h1 << `ETP_BIT_DELAY_EN) | 32'h1c;
      src(`ETP_SRC_PIN_A, 0);
      wr(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
      src(`ETP_SRC_PIN_A, 1);
      chk({cur_b, cur_on, pulse}, 0);
      rdc(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
      cfg = on_acc | (32'h1 << `ETP_BIT_HALT_IDLE) | 32'h1c;
      idle <= 1;
      src(`ETP_SRC_PIN_A, 0);
      wr(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
      src(`ETP_SRC_PIN_A, 1);
      rdc(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
      cfg = on_acc | 32'h1c;
      src(`ETP_SRC_PIN_A, 0);
      wr(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
      src(`ETP_SRC_PIN_A, 1);
      rdc(`ETP_OFS_CONTROL, cfg | 32'h1, `ETP_RESP_OKAY);
      idle <= 0;
   endtask
   task automatic t_delay();
      int n;
      wr(`ETP_OFS_IRQ_STATUS, 32'h7, `ETP_RESP_OKAY);
      rdc(`ETP_OFS_IRQ_STATUS, 32'h0, `ETP_RESP_OKAY);
      src(`ETP_SRC_PIN_A, 0);
      cfg = on_acc | (32'h1 << `ETP_BIT_DELAY_EN) | (32'h1 << `ETP_BIT_TRIG_EN) | 32'h1c;
      wr(`ETP_OFS_CONTROL, cfg, `ETP_RESP_OKAY);
      chk(cur_b, 1);
      t_rise = 0;
      @(posedge aclk);
      pin_a <= 1;
      t_edge = $realtime;
      tick(6);
      chk(cur_on, 1);
      n = 0;
      while (t_rise == 0 && n < 60)
      begin
         tick(1);
         n++;
      end
      chk(t_rise - t_edge >= CHG * 8, 1);
      // rising clock edges sit 4 ns into each 8 ns period
      chk(longint'(t_rise * 1000) % 8000 != 4000, 1);
      tick(12);
      chk({cur_on, pulse, adc_seen, irq}, 4'h2);
      rdc(`ETP_OFS_IRQ_STATUS, (32'h1 << `ETP_IRQ_E1) | (32'h1 << `ETP_IRQ_TRIP), 0);
      wr(`ETP_OFS_IRQ_MASK, 32'h5, `ETP_RESP_OKAY);
      chk(irq, 1);
      wr(`ETP_OFS_IRQ_STATUS, 32'h5, `ETP_RESP_OKAY);
      chk(irq, 0);
      wr(`ETP_OFS_CONTROL, on_acc, `ETP_RESP_OKAY);
      chk(cur_b, 0);
      wr(`ETP_OFS_CONTROL, on_acc | (32'h1 << `ETP_BIT_DISCHARGE), `ETP_RESP_OKAY);
      chk(dis_on, 1);
   endtask

   initial
   begin
      aresetn = 0;
      tick(20);
      aresetn <= 1;
      tick(2);
      rdc(`ETP_OFS_CONTROL, 32'h0, `ETP_RESP_OKAY);
      rdc(`ETP_OFS_IRQ_MASK, 32'h0, `ETP_RESP_OKAY);
      rdc(8'h0c, 32'h0, `ETP_RESP_SLVERR);
      wr(8'h0c, 32'h1, `ETP_RESP_SLVERR);
      t_edges();
      t_off_idle();
      t_delay();
      summarize();
   end
endmodule
